// ===== odtt_pkg.sv
// Purpose: constants shared by the debug trigger and trace unit
// Assumes: byte registers reached by index on the core register port
// Notes: trigger-mode and status layouts live outside this unit
// Behaviour
// - forced reset: serial writes only, reads zero
// - serial write of bit 0 resets MCU
// - compare A bytes reset zero, locked armed
// - compare B bytes reset zero, locked armed
// - FIFO high read-only, zero in event-only
// - high byte read keeps FIFO position
// - unarmed low byte read advances FIFO
// - event-only stores bytes in low half
// - low byte reads never advance while armed
// - unarmed low read stores last opcode address
// - control always accessible, enable blocked secure
// - arm set by write, cleared at end
// - bit 5 picks tag or force
// - break on trigger or FIFO full
// - bits 2,3 qualify comparator A direction
// - bits 0,1 qualify comparator B direction
// - registers reached by index on the register port, not the memory map
// - run ends on full or trigger
package odtt_pkg;
  localparam logic [3:0] IDX_CTRL = 4'h0;
  localparam logic [3:0] IDX_CAH = 4'h1;
  localparam logic [3:0] IDX_CAL = 4'h2;
  localparam logic [3:0] IDX_CBH = 4'h3;
  localparam logic [3:0] IDX_CBL = 4'h4;
  localparam logic [3:0] IDX_FH = 4'h5;
  localparam logic [3:0] IDX_FL = 4'h6;
  localparam logic [3:0] IDX_FRST = 4'h7;
  localparam int B_EN = 7;
  localparam int B_ARM = 6;
  localparam int B_TAG = 5;
  localparam int B_BRK = 4;
  localparam int B_RWA = 3;
  localparam int B_CMP_A_DIRECTION_ENABLE = 2;
  localparam int B_RWB = 1;
  localparam int B_CMP_B_DIRECTION_ENABLE = 0;
  localparam int B_FRST = 0;
  localparam logic [7:0] CMP_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] FRST_READ = 8'h00;
  localparam int FIFO_DEPTH = 8;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARMED = 3'b010,
    ST_FILL = 3'b100
  } odtt_state_t;
endpackage

// ===== odtt_buf2.sv
// Purpose: two-entry valid/ready buffer in the capture path
// Assumes: single clock, asynchronous active-low reset
// Notes: no word lost when the drain side stalls
`timescale 1ns/1ps
module odtt_buf2 #(
  parameter int W = 16
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_q [2];
  logic rd_q;
  logic wr_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;
  assign in_ready = (cnt_q != 2'd2);
  assign out_valid = (cnt_q != 2'd0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 2'd0;
    end
    else
    begin
      if (push)
        wr_q <= ~wr_q;
      if (pop)
        rd_q <= ~rd_q;
      if (push && !pop)
        cnt_q <= cnt_q + 2'd1;
      else if (pop && !push)
        cnt_q <= cnt_q - 2'd1;
    end
  end
  always_ff @(posedge mclk)
  begin
    if (push)
      mem_q[wr_q] <= in_data;
  end
endmodule

// ===== odtt_top.sv
// Purpose: debug comparators, trace FIFO and control for the core
// Assumes: bus and register port on mclk; mode inputs held steady
// Notes: register read data appears one cycle after reg_rd
`timescale 1ns/1ps
module odtt_top
  import odtt_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [3:0] reg_idx,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_serial,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  input wire logic mcu_secure,
  input wire logic event_only,
  input wire logic begin_trace,
  input wire logic trigger_qualify_select,
  input wire logic bus_valid,
  input wire logic [15:0] bus_addr,
  input wire logic bus_rnw,
  input wire logic [7:0] bus_data,
  input wire logic opcode_fetch,
  output logic break_req_q,
  output logic break_tag_q,
  output logic mcu_reset_q,
  output logic [3:0] fifo_count_q
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [3:0] FULL = 4'(DEPTH);
  odtt_state_t st_q;
  logic [7:0] ctrl_q;
  logic [15:0] cmp_a_q;
  logic [15:0] cmp_b_q;
  logic [15:0] fifo_q [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [15:0] last_op_q;
  logic armed;
  logic wr_ctrl;
  logic en_d;
  logic start_run;
  logic stop_run;
  logic match_a;
  logic match_b;
  logic trig;
  logic begin_mode;
  logic cap_valid;
  logic [15:0] cap_word;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [15:0] buf_out_data;
  logic lo_rd;
  logic push;
  logic fill_end;
  logic run_end;

  function automatic logic cmp_hit(input logic [15:0] ref_v,
    input logic [15:0] addr, input logic rnw, input logic dir,
    input logic dir_en);
    cmp_hit = (addr == ref_v) && (!dir_en || (rnw == dir));
  endfunction

  function automatic logic wr_at(input logic [3:0] idx,
    input logic [3:0] want, input logic wr);
    wr_at = wr && (idx == want);
  endfunction

  assign armed = (st_q != ST_IDLE);
  assign wr_ctrl = wr_at(reg_idx, IDX_CTRL, reg_wr);
  assign en_d = reg_wdata[B_EN] & ~mcu_secure;
  assign start_run = wr_ctrl && en_d && reg_wdata[B_ARM];
  assign stop_run = wr_ctrl && (!en_d || !reg_wdata[B_ARM]);
  assign begin_mode = begin_trace | event_only;

  // comparators watch every bus cycle while armed
  assign match_a = armed && bus_valid && cmp_hit(cmp_a_q, bus_addr,
    bus_rnw, ctrl_q[B_RWA], ctrl_q[B_CMP_A_DIRECTION_ENABLE]);
  assign match_b = armed && bus_valid && cmp_hit(cmp_b_q, bus_addr,
    bus_rnw, ctrl_q[B_RWB], ctrl_q[B_CMP_B_DIRECTION_ENABLE]);
  assign trig = event_only ? match_a : (match_a | match_b);

  always_comb
  begin
    cap_valid = 1'b0;
    cap_word = 16'h0000;
    if (event_only)
    begin
      cap_valid = (st_q == ST_FILL) && match_b;
      cap_word = {8'h00, bus_data};
    end
    else if (begin_mode)
    begin
      cap_valid = (st_q == ST_FILL) && bus_valid && opcode_fetch;
      cap_word = bus_addr;
    end
    else
    begin
      cap_valid = (st_q == ST_ARMED) && bus_valid && opcode_fetch;
      cap_word = bus_addr;
    end
  end

  // low-byte read holds the drain side for one cycle
  assign lo_rd = reg_rd && (reg_idx == IDX_FL);

  odtt_buf2 #(
    .W(16)
  ) u_buf (
    .mclk(mclk),
    .nrst(nrst),
    .in_valid(cap_valid),
    .in_ready(buf_in_ready),
    .in_data(cap_word),
    .out_valid(buf_out_valid),
    .out_ready(~lo_rd),
    .out_data(buf_out_data)
  );

  assign push = buf_out_valid && !lo_rd;
  assign fill_end = begin_mode && push && (fifo_count_q == FULL - 4'd1);
  assign run_end = (st_q == ST_FILL && fill_end)
    || (st_q == ST_ARMED && !begin_mode && trig);

  // run sequencing
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      st_q <= ST_IDLE;
    else if (start_run)
      st_q <= ST_ARMED;
    else if (stop_run || run_end)
      st_q <= ST_IDLE;
    else
    begin
      case (st_q)
        ST_IDLE: st_q <= ST_IDLE;
        ST_ARMED:
        begin
          if (begin_mode && trig)
            st_q <= ST_FILL;
        end
        ST_FILL: st_q <= ST_FILL;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // control register, arm bit mirrors run state
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      ctrl_q <= CTRL_RST;
    else if (wr_ctrl)
      ctrl_q <= {en_d, 1'b0, reg_wdata[5:0]};
  end

  // comparator bytes locked while armed
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      cmp_a_q <= {CMP_RST, CMP_RST};
      cmp_b_q <= {CMP_RST, CMP_RST};
    end
    else if (reg_wr && !armed)
    begin
      if (reg_idx == IDX_CAH)
        cmp_a_q[15:8] <= reg_wdata;
      if (reg_idx == IDX_CAL)
        cmp_a_q[7:0] <= reg_wdata;
      if (reg_idx == IDX_CBH)
        cmp_b_q[15:8] <= reg_wdata;
      if (reg_idx == IDX_CBL)
        cmp_b_q[7:0] <= reg_wdata;
    end
  end

  // most recent opcode fetch address
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      last_op_q <= 16'h0000;
    else if (bus_valid && opcode_fetch)
      last_op_q <= bus_addr;
  end

  // fifo pointers and valid count
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      fifo_count_q <= 4'h0;
    end
    else if (start_run)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      fifo_count_q <= 4'h0;
    end
    else if (push)
    begin
      wr_ptr_q <= wr_ptr_q + PW'(1);
      if (fifo_count_q == FULL)
        rd_ptr_q <= rd_ptr_q + PW'(1);
      else
        fifo_count_q <= fifo_count_q + 4'h1;
    end
    else if (lo_rd && !armed)
      rd_ptr_q <= rd_ptr_q + PW'(1);
  end

  // fifo storage
  always_ff @(posedge mclk)
  begin
    if (push)
      fifo_q[wr_ptr_q] <= buf_out_data;
    else if (lo_rd && !armed)
      fifo_q[rd_ptr_q] <= last_op_q;
  end

  // register read data
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      reg_rdata_q <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_idx)
        IDX_CTRL: reg_rdata_q <= {ctrl_q[7], armed, ctrl_q[5:0]};
        IDX_CAH: reg_rdata_q <= cmp_a_q[15:8];
        IDX_CAL: reg_rdata_q <= cmp_a_q[7:0];
        IDX_CBH: reg_rdata_q <= cmp_b_q[15:8];
        IDX_CBL: reg_rdata_q <= cmp_b_q[7:0];
        IDX_FH: reg_rdata_q <= event_only ? 8'h00
          : fifo_q[rd_ptr_q][15:8];
        IDX_FL: reg_rdata_q <= fifo_q[rd_ptr_q][7:0];
        IDX_FRST: reg_rdata_q <= FRST_READ;
        default: reg_rdata_q <= 8'h00;
      endcase
    end
  end

  // break requests to the core
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      break_req_q <= 1'b0;
      break_tag_q <= 1'b0;
    end
    else
    begin
      break_req_q <= ctrl_q[B_BRK] && !stop_run
        && ((st_q == ST_ARMED && !begin_mode && trig)
        || (st_q == ST_FILL && fill_end));
      break_tag_q <= ctrl_q[B_BRK] && ctrl_q[B_TAG];
    end
  end

  // forced reset, serial debug writes only
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      mcu_reset_q <= 1'b0;
    else
      mcu_reset_q <= wr_at(reg_idx, IDX_FRST, reg_wr) && reg_serial
        && reg_wdata[B_FRST];
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  a_frst_user: assert property (
    wr_at(reg_idx, IDX_FRST, reg_wr) && !reg_serial |=> !mcu_reset_q)
    else $error("user write reached forced reset");
  a_frst_serial: assert property (
    wr_at(reg_idx, IDX_FRST, reg_wr) && reg_serial && reg_wdata[0]
    |=> mcu_reset_q)
    else $error("serial forced reset not raised");
  a_cmp_lock: assert property (
    armed && !start_run |=> $stable(cmp_a_q) && $stable(cmp_b_q))
    else $error("comparator changed while armed");
  a_fh_zero: assert property (
    reg_rd && reg_idx == IDX_FH && event_only |=> reg_rdata_q == 8'h00)
    else $error("fifo high not zero in event mode");
  a_fh_hold: assert property (
    reg_rd && reg_idx == IDX_FH && !push && !start_run
    |=> $stable(rd_ptr_q))
    else $error("fifo high read moved pointer");
  a_fl_armed: assert property (
    lo_rd && armed && !push && !start_run |=> $stable(rd_ptr_q))
    else $error("fifo advanced while armed");
  a_fl_adv: assert property (
    lo_rd && !armed && !start_run |=> rd_ptr_q == $past(rd_ptr_q) + PW'(1))
    else $error("fifo low read did not advance");
  a_en_secure: assert property (
    wr_ctrl && mcu_secure |=> !ctrl_q[B_EN] && !armed)
    else $error("enable set while secure");
  a_brk_off: assert property (
    !ctrl_q[B_BRK] |=> !break_req_q)
    else $error("break with breaks disabled");
  a_end_run: assert property (
    st_q == ST_ARMED && !begin_mode && trig && !wr_ctrl |=> !armed)
    else $error("end trace run not finished");
  a_dir_a: assert property (
    ctrl_q[B_CMP_A_DIRECTION_ENABLE] && bus_rnw != ctrl_q[B_RWA] |-> !match_a)
    else $error("comparator A direction ignored");
  a_dir_b: assert property (
    ctrl_q[B_CMP_B_DIRECTION_ENABLE] && bus_rnw != ctrl_q[B_RWB] |-> !match_b)
    else $error("comparator B direction ignored");
  a_tag_type: assert property (
    ctrl_q[B_BRK] |=> break_tag_q == $past(ctrl_q[B_TAG]))
    else $error("break type does not follow tag bit");
  a_brk_full: assert property (
    ctrl_q[B_BRK] && st_q == ST_FILL && fill_end && !stop_run |=> break_req_q)
    else $error("no break when begin trace filled");
  a_run_full: assert property (
    st_q == ST_FILL && fill_end && !start_run |=> !armed)
    else $error("begin trace run not finished");
  a_frst_read: assert property (
    reg_rd && reg_idx == IDX_FRST |=> reg_rdata_q == FRST_READ)
    else $error("forced reset read not zero");
  a_arm_start: assert property (
    start_run |=> st_q == ST_ARMED)
    else $error("arm write did not start run");
  a_stop_run: assert property (
    stop_run |=> !armed)
    else $error("run not aborted by control write");

  c_end_trace: cover property (st_q == ST_ARMED ##1 st_q == ST_IDLE);
  c_begin_full: cover property (st_q == ST_FILL ##1 fifo_count_q == FULL);
  c_profile: cover property (lo_rd && !armed ##1 lo_rd && !armed);
  c_break: cover property (break_req_q && break_tag_q);
  c_cap_drop: cover property (cap_valid && !buf_in_ready);
endmodule

// ===== odtt_cpu_model.sv
// Purpose: core bus side, issues bus cycles and counts breaks
// Assumes: one bus cycle per call, fields inverted when idle
// Notes: tag level is latched with each break pulse
`timescale 1ns/1ps
module odtt_cpu_model (
  input wire logic mclk,
  output logic bus_valid,
  output logic [15:0] bus_addr,
  output logic bus_rnw,
  output logic [7:0] bus_data,
  output logic opcode_fetch,
  input wire logic break_req_q,
  input wire logic break_tag_q
);
  int brks = 0;
  logic tag_seen = 1'b0;
  initial
  begin
    bus_valid = 1'b0;
    bus_addr = 16'h0000;
    bus_rnw = 1'b1;
    bus_data = 8'h00;
    opcode_fetch = 1'b0;
  end
  always @(posedge mclk)
    if (break_req_q === 1'b1)
    begin
      brks <= brks + 1;
      tag_seen <= break_tag_q;
    end
  task automatic cyc(input logic [15:0] a, input logic rw, input logic f);
    @(posedge mclk);
    bus_valid <= 1'b1;
    bus_addr <= a;
    bus_rnw <= rw;
    bus_data <= a[7:0];
    opcode_fetch <= f;
    @(posedge mclk);
    bus_valid <= 1'b0;
    bus_addr <= ~a;
    bus_rnw <= ~rw;
    bus_data <= ~a[7:0];
    opcode_fetch <= 1'b0;
  endtask
endmodule

// ===== odtt_top_tb.sv
// Purpose: register port sequences with expected values
// Assumes: read data settles one edge after the read strobe
// Notes: comparators set to 1234 and 5678 for break tests
`timescale 1ns/1ps
module odtt_top_tb;
  import odtt_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] reg_idx = 4'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic reg_serial = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic mcu_secure = 1'b0;
  logic event_only = 1'b0;
  logic begin_trace = 1'b0;
  logic bus_valid, bus_rnw, opcode_fetch;
  logic [15:0] bus_addr;
  logic [7:0] bus_data, reg_rdata_q, h, l;
  logic break_req_q, break_tag_q, mcu_reset_q;
  logic [3:0] fifo_count_q;
  int errors = 0;
  int checks_done = 0;
  int rsts = 0;
  int b0;
  logic [7:0] tc[9] = '{8'hD0, 8'hC0, 8'hDC, 8'hDC, 8'hD4, 8'hD8,
    8'hD1, 8'hD1, 8'hF0};
  logic [15:0] ta[9] = '{16'h1234, 16'h1234, 16'h1234, 16'h1234,
    16'h1234, 16'h1234, 16'h5678, 16'h5678, 16'h1234};
  logic tr[9] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  logic tn[9] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  odtt_top i_odtt_top (.mclk(mclk), .nrst(nrst), .reg_idx(reg_idx),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_serial(reg_serial),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .mcu_secure(mcu_secure), .event_only(event_only),
    .begin_trace(begin_trace), .trigger_qualify_select(1'b0),
    .bus_valid(bus_valid), .bus_addr(bus_addr), .bus_rnw(bus_rnw),
    .bus_data(bus_data), .opcode_fetch(opcode_fetch),
    .break_req_q(break_req_q), .break_tag_q(break_tag_q),
    .mcu_reset_q(mcu_reset_q), .fifo_count_q(fifo_count_q));
  odtt_cpu_model i_odtt_cpu_model (.mclk(mclk), .bus_valid(bus_valid),
    .bus_addr(bus_addr), .bus_rnw(bus_rnw), .bus_data(bus_data),
    .opcode_fetch(opcode_fetch), .break_req_q(break_req_q),
    .break_tag_q(break_tag_q));
  initial
  begin
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk)
    if (mcu_reset_q === 1'b1)
      rsts <= rsts + 1;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] i, input logic [7:0] d,
    input logic s);
    @(posedge mclk);
    reg_idx <= i;
    reg_wdata <= d;
    reg_serial <= s;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_serial <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] i, output logic [7:0] v);
    @(posedge mclk);
    reg_idx <= i;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    v = reg_rdata_q;
  endtask
  task automatic rchk(input logic [3:0] i, input logic [7:0] e);
    logic [7:0] v;
    rd(i, v);
    chk(16'(v), 16'(e));
  endtask
  task automatic test_done;
    $display("checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #2000000;
    errors++;
    test_done;
  end
  initial
  begin
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    rchk(IDX_CAH, 8'h00);
    rchk(IDX_CAL, 8'h00);
    rchk(IDX_CBH, 8'h00);
    rchk(IDX_CBL, 8'h00);
    rchk(IDX_FRST, 8'h00);
    $display("test reset values done");
    wr(IDX_FRST, 8'h01, 1'b0);
    repeat (3) @(posedge mclk);
    chk(16'(rsts), 16'h0000);
    wr(IDX_FRST, 8'h01, 1'b1);
    repeat (3) @(posedge mclk);
    chk(16'(rsts), 16'h0001);
    $display("test forced reset done");
    mcu_secure <= 1'b1;
    wr(IDX_CTRL, 8'h80, 1'b0);
    rchk(IDX_CTRL, 8'h00);
    mcu_secure <= 1'b0;
    wr(IDX_CAH, 8'h12, 1'b0);
    wr(IDX_CAL, 8'h34, 1'b0);
    wr(IDX_CBH, 8'h56, 1'b0);
    wr(IDX_CBL, 8'h78, 1'b0);
    wr(IDX_CTRL, 8'hC0, 1'b0);
    rchk(IDX_CTRL, 8'hC0);
    wr(IDX_CAH, 8'hAA, 1'b0);
    wr(IDX_CBL, 8'hAA, 1'b0);
    rchk(IDX_CAH, 8'h12);
    rchk(IDX_CBL, 8'h78);
    $display("test lock and secure done");
    for (int k = 0; k < 9; k++)
    begin
      b0 = i_odtt_cpu_model.brks;
      wr(IDX_CTRL, tc[k], 1'b0);
      i_odtt_cpu_model.cyc(ta[k], tr[k], 1'b0);
      repeat (3) @(posedge mclk);
      chk(16'(i_odtt_cpu_model.brks - b0), 16'(tn[k]));
      if (tn[k])
        chk(16'(i_odtt_cpu_model.tag_seen), 16'(tc[k][B_TAG]));
      wr(IDX_CTRL, 8'h80, 1'b0);
      rchk(IDX_CTRL, 8'h80);
    end
    $display("test end trace breaks done");
    begin_trace <= 1'b1;
    b0 = i_odtt_cpu_model.brks;
    wr(IDX_CTRL, 8'hD0, 1'b0);
    i_odtt_cpu_model.cyc(16'h1234, 1'b1, 1'b1);
    repeat (2) @(posedge mclk);
    chk(16'(i_odtt_cpu_model.brks - b0), 16'h0000);
    for (int k = 0; k < 40 && i_odtt_cpu_model.brks == b0; k++)
      i_odtt_cpu_model.cyc(16'h2000 + 16'(k), 1'b1, 1'b1);
    if (i_odtt_cpu_model.brks == b0)
    begin
      errors++;
      test_done;
    end
    chk(16'(fifo_count_q), 16'(FIFO_DEPTH));
    rchk(IDX_CTRL, 8'h90);
    $display("test begin trace done");
    begin_trace <= 1'b0;
    wr(IDX_CTRL, 8'h00, 1'b0);
    for (int k = 0; k < 16; k++)
    begin
      i_odtt_cpu_model.cyc(16'h3100 + 16'(k) * 16'h0101, 1'b1, 1'b1);
      rd(IDX_FH, h);
      rd(IDX_FH, h);
      rd(IDX_FL, l);
      if (k >= 8)
        chk({h, l}, 16'h3100 + 16'(k - 8) * 16'h0101);
    end
    $display("test profiling done");
    event_only <= 1'b1;
    wr(IDX_FH, 8'hFF, 1'b0);
    rchk(IDX_FH, 8'h00);
    wr(IDX_CTRL, 8'hC0, 1'b0);
    i_odtt_cpu_model.cyc(16'h1234, 1'b1, 1'b0);
    i_odtt_cpu_model.cyc(16'h5678, 1'b0, 1'b0);
    i_odtt_cpu_model.cyc(16'h5678, 1'b0, 1'b0);
    wr(IDX_CTRL, 8'h80, 1'b0);
    chk(16'(fifo_count_q), 16'h0002);
    rchk(IDX_FL, 8'h78);
    rchk(IDX_FL, 8'h78);
    rchk(IDX_FH, 8'h00);
    $display("test event only high byte done");
    test_done;
  end
endmodule
